// File: hw/sac_conv.sv
// Purpose: Device side serial control of a 10-bit converter with 11 inputs
// Assumes: Chip select, I/O clock and address arrive from another domain
// Notes:   Analog result enters on i_adc_bit, one bit per converter clock

// Function
// - Cycle starts when chip select falls low
// - Address bit latched on I/O clock rise
// - Result bit shifted out on falling edge
// - Sampling runs from fourth to tenth fall
// - Raise select then convert for 44 clocks
// - Early select change aborts the conversion
// - System and I/O clocks fully independent
// - Address picks input or self-test
module sac_conv (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Serial control pins
   input wire logic i_cs_b,
   input wire logic i_io_clk,
   input wire logic i_addr,
   output logic o_dout,
   output logic o_dout_oe,
   // Analog front end
   input wire logic i_adc_bit,
   output sac_pkg::sac_mux_t o_mux,
   output logic o_busy
);
   import sac_pkg::*;

   // Two-stage synchronisers for the pins
   logic [2:0] sync1_q, sync2_q;
   logic cs_prev_q, clk_prev_q;
   logic cs_b, ioclk, addr_s;
   logic rise, fall, cs_fall, cs_rise;

   // State registers
   sac_state_t st_q, st_d;
   logic [3:0] pulse_q, pulse_d;
   logic [3:0] adr_q, adr_d;
   logic [9:0] out_q, out_d;      // Bits being shifted out
   logic [9:0] res_q, res_d;      // Last completed conversion
   logic [9:0] acc_q, acc_d;      // Conversion in progress
   logic [5:0] conv_q, conv_d;
   logic [7:0] div_q, div_d;
   logic dout_q, dout_d, oe_q, oe_d, busy_q, busy_d;
   sac_mux_t mux_q, mux_d;
   logic sys_en;

   // Synchronise pins; first stage only feeds second
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // Idle pin levels: select high, clock low, so no false edge
         sync1_q <= 3'h4;
         sync2_q <= 3'h4;
         cs_prev_q <= 1'b1;
         clk_prev_q <= 1'b0;
      end else begin
         sync1_q <= {i_cs_b, i_io_clk, i_addr};
         sync2_q <= sync1_q;
         cs_prev_q <= sync2_q[2];
         clk_prev_q <= sync2_q[1];
      end
   end

   // Edge detection on synchronised levels
   always_comb begin
      cs_b = sync2_q[2];
      ioclk = sync2_q[1];
      addr_s = sync2_q[0];
      rise = ioclk && !clk_prev_q && !cs_b;
      fall = !ioclk && clk_prev_q && !cs_b;
      cs_fall = !cs_b && cs_prev_q;
      cs_rise = cs_b && !cs_prev_q;
   end

   // Converter system clock enable, free running and independent
   always_comb begin
      sys_en = (div_q == 8'(SAC_SYS_DIV - 1));
      div_d = sys_en ? 8'h00 : div_q + 8'h01;
   end

   // Next-state logic for the serial cycle and conversion
   always_comb begin
      st_d = st_q;
      pulse_d = pulse_q;
      adr_d = adr_q;
      out_d = out_q;
      res_d = res_q;
      acc_d = acc_q;
      conv_d = conv_q;
      dout_d = dout_q;
      oe_d = oe_q;
      busy_d = busy_q;
      mux_d = mux_q;
      if (cs_fall) begin
         // New cycle; abort any conversion still running
         st_d = SAC_SHIFT;
         pulse_d = 4'h0;
         busy_d = 1'b0;
         out_d = {res_q[8:0], 1'b0};
         dout_d = res_q[9];   // Previous result, MSB first
         oe_d = 1'b1;
         mux_d.sample = 1'b0;
      end else if (cs_b) begin
         // Deselected: ignore pins, float the output
         oe_d = 1'b0;
         mux_d.sample = 1'b0;
         if (cs_rise && st_q == SAC_SHIFT && pulse_q == SAC_PULSES) begin
            // Ten pulses done; hold sample and convert
            st_d = SAC_CONV;
            conv_d = 6'h00;
            busy_d = 1'b1;
            acc_d = 10'h000;
         end else if (cs_rise) begin
            st_d = SAC_IDLE;   // Incomplete cycle discarded
            busy_d = 1'b0;
         end else if (st_q == SAC_CONV && sys_en) begin
            acc_d = {acc_q[8:0], i_adc_bit};
            if (conv_q == SAC_CONV_CYC - 6'h01) begin
               st_d = SAC_IDLE;
               busy_d = 1'b0;
               res_d = {acc_q[8:0], i_adc_bit};
            end else begin
               conv_d = conv_q + 6'h01;
            end
         end
      end else if (st_q == SAC_SHIFT) begin
         if (rise && pulse_q < SAC_ADR_W[3:0]) begin
            adr_d = {adr_q[2:0], addr_s};
         end
         if (fall && pulse_q < SAC_PULSES) begin
            pulse_d = pulse_q + 4'h1;
            dout_d = out_q[9];
            out_d = {out_q[8:0], 1'b0};
            if (pulse_q + 4'h1 == SAC_SAMP_START) begin
               // Select input or self-test and start sampling
               mux_d.channel = adr_q;
               mux_d.self_test = (adr_q >= SAC_NUM_IN);
               mux_d.sample = 1'b1;
            end else if (pulse_q + 4'h1 == SAC_PULSES) begin
               mux_d.sample = 1'b0;
            end
         end
      end
   end

   // Register all state
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= SAC_IDLE;
         pulse_q <= 4'h0;
         adr_q <= 4'h0;
         out_q <= SAC_RES_RST;
         res_q <= SAC_RES_RST;
         acc_q <= SAC_RES_RST;
         conv_q <= 6'h00;
         div_q <= 8'h00;
         dout_q <= 1'b0;
         oe_q <= 1'b0;
         busy_q <= 1'b0;
         mux_q <= '0;
      end else begin
         st_q <= st_d;
         pulse_q <= pulse_d;
         adr_q <= adr_d;
         out_q <= out_d;
         res_q <= res_d;
         acc_q <= acc_d;
         conv_q <= conv_d;
         div_q <= div_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
         busy_q <= busy_d;
         mux_q <= mux_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_dout = dout_q;
   assign o_dout_oe = oe_q;
   assign o_mux = mux_q;
   assign o_busy = busy_q;

   // Assertions
   property p_float;
      @(posedge i_clk) disable iff (!i_rst_b)
         (cs_b && !cs_fall) |=> !o_dout_oe;
   endproperty
   a_float: assert property (p_float) else $error("output driven");

   property p_drive;
      @(posedge i_clk) disable iff (!i_rst_b)
         cs_fall |=> o_dout_oe && o_dout == $past(res_q[9]);
   endproperty
   a_drive: assert property (p_drive) else $error("first bit wrong");

   property p_shift;
      @(posedge i_clk) disable iff (!i_rst_b)
         (fall && !cs_fall && st_q == SAC_SHIFT && pulse_q < SAC_PULSES)
            |=> o_dout == $past(out_q[9]);
   endproperty
   a_shift: assert property (p_shift) else $error("bad shift");

   property p_adr;
      @(posedge i_clk) disable iff (!i_rst_b)
         (rise && !cs_fall && st_q == SAC_SHIFT && pulse_q < 4'h4)
            |=> adr_q[0] == $past(addr_s);
   endproperty
   a_adr: assert property (p_adr) else $error("addr not latched");

   property p_samp;
      @(posedge i_clk) disable iff (!i_rst_b)
         (fall && !cs_fall && st_q == SAC_SHIFT && pulse_q == 4'h3)
            |=> o_mux.sample;
   endproperty
   a_samp: assert property (p_samp) else $error("no sample");

   property p_sel;
      @(posedge i_clk) disable iff (!i_rst_b)
         $rose(o_mux.sample) |-> o_mux.self_test == (o_mux.channel > 4'ha);
   endproperty
   a_sel: assert property (p_sel) else $error("bad select");

   // Tenth pulse done and select raised
   sequence s_ten_done;
      cs_rise && st_q == SAC_SHIFT && pulse_q == SAC_PULSES;
   endsequence
   // Converting with the sample window closed
   sequence s_converting;
      o_busy && !o_mux.sample;
   endsequence
   property p_conv;
      @(posedge i_clk) disable iff (!i_rst_b)
         s_ten_done |=> s_converting;
   endproperty
   a_conv: assert property (p_conv) else $error("no conversion");

   property p_abort;
      @(posedge i_clk) disable iff (!i_rst_b)
         (cs_fall && st_q == SAC_CONV) |=> !o_busy && st_q == SAC_SHIFT;
   endproperty
   a_abort: assert property (p_abort) else $error("no abort");
endmodule

// File: hw/sac_pkg.sv
// Purpose: Shared constants and types for the serial converter interface
// Assumes: 10 MHz block clock, converter system clock is an enable pulse
// Notes:   Timing counts derive from the printed figures

package sac_pkg;

   // Result width and address width
   localparam int SAC_RES_W = 10;
   localparam int SAC_ADR_W = 4;
   // Pulse count per cycle
   localparam logic [3:0] SAC_PULSES = 4'h000a;
   // Pulse at whose falling edge sampling starts
   localparam logic [3:0] SAC_SAMP_START = 4'h0004;
   // Conversion length in converter system clock cycles
   localparam logic [5:0] SAC_CONV_CYC = 6'h002c;
   // Block clock rate and converter system clock rate in kHz
   localparam int SAC_CLK_KHZ = 10000;
   localparam int SAC_SYS_KHZ = 2100;
   // Block cycles per converter clock, rounded up so the limit holds
   localparam int SAC_SYS_DIV =
      (SAC_CLK_KHZ + SAC_SYS_KHZ - 1) / SAC_SYS_KHZ;
   // Number of analog inputs; codes at or above it select self-test
   localparam logic [3:0] SAC_NUM_IN = 4'h000b;
   // Reset value of the result register
   localparam logic [9:0] SAC_RES_RST = 10'h0000;

   // Converter phase
   typedef enum logic [1:0] {
      SAC_IDLE = 2'b00,
      SAC_SHIFT = 2'b01,
      SAC_CONV = 2'b10
   } sac_state_t;

   // Analog front-end controls
   typedef struct packed {
      logic sample;
      logic self_test;
      logic [3:0] channel;
   } sac_mux_t;

endpackage

// File: verif/sac_host.sv
// Purpose: Host model driving the converter serial pins
// Assumes: I/O clock period 800 ns, phase free of block clock
// Notes:   Captures each result bit just before the clock fall
module sac_host (
   // From the converter
   input wire logic i_dout,
   // Toward the converter
   output logic o_cs_b,
   output logic o_io_clk,
   output logic o_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   // Deselected, clock parked low
   initial begin
      o_cs_b = 1'b1;
      o_io_clk = 1'b0;
      o_addr = 1'b0;
   end
   // Unused address line wiggles so no stale level helps
   always #130 if (o_cs_b) o_addr = ~o_addr;
   // Move select, then let the pins settle
   task automatic sel(input logic lvl);
      o_cs_b = lvl;
      #1000;
   endtask
   // One pulse: address before the rise, data taken at the fall
   task automatic pulse(input logic a, output logic d);
      o_addr = a;
      #200 o_io_clk = 1'b1;
      #400 d = i_dout;
      o_io_clk = 1'b0;
      #200;
   endtask
endmodule

// File: verif/test_sac_conv.sv
// Purpose: Self-checking bench for the converter serial control
// Assumes: Conversion bit held steady through each conversion
// Notes:   Expected result is the previous stored conversion
module test_sac_conv;
   timeunit 1ns;
   timeprecision 1ns;
   import sac_pkg::*;
   logic i_clk, i_rst_b, i_adc_bit, cs_b, io_clk, addr, dout, oe, busy;
   sac_mux_t mux;
   int fail_count = 0;
   int n_checks = 0;
   logic [9:0] prev; // Last stored result
   sac_conv dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
      .i_io_clk(io_clk), .i_addr(addr), .o_dout(dout), .o_dout_oe(oe),
      .i_adc_bit(i_adc_bit), .o_mux(mux), .o_busy(busy));
   // Released data line shows the inverse so a stale level cannot help
   sac_host host_u (.i_dout(oe ? dout : !dout), .o_cs_b(cs_b),
      .o_io_clk(io_clk), .o_addr(addr));
   // Block clock, 100 ns
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   // Compare and count
   task automatic check(input logic [15:0] seen, exp, input string m);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One cycle; ab above zero reselects during conversion
   task automatic frame(input logic [3:0] ch, input logic b, input int ab);
      logic [9:0] got;
      logic d;
      int n;
      int conv;
      int len;
      conv = SAC_CONV_CYC * SAC_SYS_DIV;
      got = '0;
      n = 0;
      @(negedge i_clk);
      i_adc_bit = b;
      #37;
      host_u.sel(1'b0);
      check(oe, 1'b1, "output not driven");
      for (int i = 0; i < 10; i++) begin
         host_u.pulse(i < 4 ? ch[3 - i] : i[0], d);
         got = {got[8:0], d};
         if (i == 5) begin
            check(mux.sample, 1'b1, "not sampling");
            check(mux.self_test, ch >= SAC_NUM_IN, "self test");
            if (ch < SAC_NUM_IN)
               check(mux.channel, ch, "channel");
         end
      end
      check(got, prev, "result bits");
      #500;
      check(mux.sample, 1'b0, "still sampling");
      host_u.sel(1'b1);
      check(oe, 1'b0, "output driven");
      check(busy, 1'b1, "no conversion");
      if (ab > 0) begin
         repeat (ab) @(negedge i_clk);
         host_u.sel(1'b0);
         check(busy, 1'b0, "not aborted");
         host_u.sel(1'b1);
         check(busy, 1'b0, "short cycle converted");
      end else begin
         while (busy === 1'b1 && n < 400) begin
            @(negedge i_clk);
            n++;
         end
         if (n >= 400) begin
            fail_count++; // Timeout counts as a mismatch
            finish_test();
         end
         len = n + 10; // Cycles since the select pin rose
         check(len >= conv - 5 && len <= conv + 5, 1'b1, "length");
         prev = {10{b}};
      end
   endtask
   // Main sequence
   initial begin
      i_rst_b = 1'b0;
      i_adc_bit = 1'b0;
      prev = SAC_RES_RST;
      repeat (4) @(negedge i_clk);
      check(oe, 1'b0, "oe in reset");
      check(busy, 1'b0, "busy in reset");
      i_rst_b = 1'b1;
      for (int c = 0; c < 16; c++)
         frame(4'(c), c[0], 0);
      frame(4'h5, 1'b0, 50);
      frame(4'h5, 1'b1, 0);
      frame(4'h0, 1'b0, 0);
      finish_test();
   end
endmodule
